/* hw/sst_pkg.sv */
// Constants, register map and types for the synchronous serial transmitter.
package sst_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PULSE_NS      = 14000;
  localparam int unsigned PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOW_NS        = 1000;
  localparam int unsigned LOW_CYC       = (LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 10;
  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] LOW_CNT   = CNT_W'(LOW_CYC - 1);

  localparam int unsigned NPINS  = 16;
  localparam int unsigned ITEM_W = 21;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DATA   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PINS   = 8'h0c;

  // Control register fields.
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_ORDER_BIT = 1;
  localparam int unsigned CTRL_DPIN_LSB  = 4;
  localparam int unsigned CTRL_CPIN_LSB  = 8;
  localparam logic [11:0] CTRL_RESET     = 12'h000;

  // Data register fields.
  localparam int unsigned DATA_BITS_LSB = 16;
  localparam logic [4:0]  DEFAULT_BITS  = 5'h08;
  localparam logic [4:0]  MAX_BITS      = 5'h10;

  // Status register fields.
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_FULL_BIT  = 1;
  localparam int unsigned STAT_EMPTY_BIT = 2;

  // Order selector encodings.
  localparam logic LOW_BIT_FIRST  = 1'b0;
  localparam logic HIGH_BIT_FIRST = 1'b1;

  typedef enum logic [5:0] {
    SST_IDLE    = 6'b000001,
    SST_CLKLOW  = 6'b000010,
    SST_PRESENT = 6'b000100,
    SST_ENABLE  = 6'b001000,
    SST_PULSE   = 6'b010000,
    SST_LOW     = 6'b100000
  } sst_state_t;

endpackage : sst_pkg

/* hw/sst_stream_if.sv */
// Valid/ready stream carrying one data item between the bus side and the shifter.
`timescale 1ns/10ps
interface sst_stream_if;
  import sst_pkg::*;
  logic              valid;
  logic              ready;
  logic [ITEM_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sst_stream_if

/* hw/sst_fifo2.sv */
// Two-entry item buffer with valid and ready on both sides.
`timescale 1ns/10ps
module sst_fifo2
  import sst_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  clk_en,
  // Streams.
  sst_stream_if.snk  in_s,
  sst_stream_if.src  out_s
);
  import sst_pkg::*;

  localparam int unsigned DEPTH = 2;

  logic [ITEM_W-1:0] mem_reg [DEPTH];
  logic [ITEM_W-1:0] mem_next [DEPTH];
  logic              wr_ptr_reg, wr_ptr_next;
  logic              rd_ptr_reg, rd_ptr_next;
  logic [1:0]        count_reg, count_next;
  logic              push, pop;

  assign in_s.ready  = (count_reg != 2'h2);
  assign out_s.valid = (count_reg != 2'h0);
  assign out_s.data  = mem_reg[rd_ptr_reg];
  assign push        = clk_en & in_s.valid & in_s.ready;
  assign pop         = clk_en & out_s.valid & out_s.ready;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_s.data;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    case ({push, pop})
      2'b10:   count_next = count_reg + 2'h1;
      2'b01:   count_next = count_reg - 2'h1;
      default: count_next = count_reg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  property p_fifo_bound;
    @(posedge pclk) disable iff (!presetn) count_reg <= 2'h2;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count above depth");

  property p_fifo_full_stalls;
    @(posedge pclk) disable iff (!presetn)
      (count_reg == 2'h2 && !pop && clk_en) |=> (count_reg == 2'h2 && !in_s.ready);
  endproperty
  a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("full buffer accepted");

endmodule : sst_fifo2

/* hw/sst_top.sv */
// Synchronous serial transmitter: APB registers, item buffer and bit shifter.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module sst_top
  import sst_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Port pins: output latch bank and direction.
  output logic [sst_pkg::NPINS-1:0] pin_out,
  output logic [sst_pkg::NPINS-1:0] pin_oe,
  // Status.
  output logic                   busy
);
  import sst_pkg::*;

  // Register hit decode, shared by the read and write paths.
  function automatic logic sst_hit(input logic [7:0] addr, input logic [7:0] offs);
    return addr == offs;
  endfunction : sst_hit

  // Turns a bus item into a shifter image and a bit count.
  function automatic logic [20:0] sst_load(input logic [ITEM_W-1:0] item, input logic ord);
    logic [4:0]  n;
    logic [15:0] d;
    n = item[DATA_BITS_LSB +: 5];
    d = item[15:0];
    if (n == 5'h00) begin
      n = DEFAULT_BITS;
    end else if (n > MAX_BITS) begin
      n = MAX_BITS;
    end
    if (ord == HIGH_BIT_FIRST) begin
      d = d << (5'h10 - n);
    end
    return {n, d};
  endfunction : sst_load

  sst_stream_if wr_s ();
  sst_stream_if rd_s ();

  sst_fifo2 u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .in_s    (wr_s),
    .out_s   (rd_s)
  );

  // Bus side state.
  logic [11:0]      ctrl_reg, ctrl_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic             setup, access, mapped, data_wr;

  // Shifter state.
  sst_state_t       st_reg, st_next;
  logic [15:0]      sh_reg, sh_next;
  logic [4:0]       left_reg, left_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             ord_reg, ord_next;
  logic [3:0]       dpin_reg, dpin_next;
  logic [3:0]       cpin_reg, cpin_next;
  logic [NPINS-1:0] latch_reg, latch_next;
  logic [NPINS-1:0] dir_reg, dir_next;
  logic             take;
  logic [20:0]      img;

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign mapped  = sst_hit(paddr, ADDR_CTRL) | sst_hit(paddr, ADDR_DATA) |
                   sst_hit(paddr, ADDR_STATUS) | sst_hit(paddr, ADDR_PINS);
  assign data_wr = access & pwrite & sst_hit(paddr, ADDR_DATA);

  // A data write waits while the buffer is full, so no item is lost while clk_en is high.
  assign pready     = ~(data_wr & ~wr_s.ready);
  assign pslverr    = access & ~mapped;
  assign prdata     = prdata_reg;
  assign wr_s.valid = data_wr;
  assign wr_s.data  = pwdata[ITEM_W-1:0];

  always_comb begin
    ctrl_next   = ctrl_reg;
    prdata_next = prdata_reg;
    if (setup && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (sst_hit(paddr, ADDR_CTRL)) begin
        prdata_next = {20'h00000, ctrl_reg};
      end
      if (sst_hit(paddr, ADDR_STATUS)) begin
        prdata_next[STAT_BUSY_BIT]  = (st_reg != SST_IDLE);
        prdata_next[STAT_FULL_BIT]  = ~wr_s.ready;
        prdata_next[STAT_EMPTY_BIT] = ~rd_s.valid;
      end
      if (sst_hit(paddr, ADDR_PINS)) begin
        prdata_next = {dir_reg, latch_reg};
      end
    end
    if (access && pwrite && sst_hit(paddr, ADDR_CTRL)) begin
      ctrl_next = pwdata[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl_reg   <= ctrl_next;
      prdata_reg <= prdata_next;
    end
  end

  // Shifter: one item after another while enabled and the buffer holds work.
  assign img        = sst_load(rd_s.data, ord_reg);
  assign rd_s.ready = take;

  always_comb begin
    st_next    = st_reg;
    sh_next    = sh_reg;
    left_next  = left_reg;
    cnt_next   = cnt_reg;
    ord_next   = ord_reg;
    dpin_next  = dpin_reg;
    cpin_next  = cpin_reg;
    latch_next = latch_reg;
    dir_next   = dir_reg;
    take       = 1'b0;
    unique case (st_reg)
      SST_IDLE: begin
        ord_next  = ctrl_reg[CTRL_ORDER_BIT];
        dpin_next = ctrl_reg[CTRL_DPIN_LSB +: 4];
        cpin_next = ctrl_reg[CTRL_CPIN_LSB +: 4];
        if (ctrl_reg[CTRL_EN_BIT] && rd_s.valid) begin
          st_next = SST_CLKLOW;
        end
      end
      SST_CLKLOW: begin
        latch_next[cpin_reg] = 1'b0;
        dir_next[cpin_reg]   = 1'b1;
        take                 = 1'b1;
        sh_next              = img[15:0];
        left_next            = img[20:16];
        st_next              = SST_PRESENT;
      end
      SST_PRESENT: begin
        latch_next[dpin_reg] = (ord_reg == HIGH_BIT_FIRST) ? sh_reg[15] : sh_reg[0];
        st_next              = SST_ENABLE;
      end
      SST_ENABLE: begin
        dir_next[dpin_reg] = 1'b1;
        cnt_next           = '0;
        st_next            = SST_PULSE;
      end
      SST_PULSE: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg == '0) begin
          latch_next[cpin_reg] = 1'b1;
        end
        if (cnt_reg == PULSE_CNT) begin
          latch_next[cpin_reg] = 1'b0;
          cnt_next             = '0;
          st_next              = SST_LOW;
        end
      end
      SST_LOW: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg == LOW_CNT) begin
          cnt_next  = '0;
          left_next = left_reg - 5'h01;
          sh_next   = (ord_reg == HIGH_BIT_FIRST) ? (sh_reg << 1) : (sh_reg >> 1);
          if (left_reg != 5'h01) begin
            st_next = SST_PRESENT;
          end else if (ctrl_reg[CTRL_EN_BIT] && rd_s.valid) begin
            take      = 1'b1;
            sh_next   = img[15:0];
            left_next = img[20:16];
            st_next   = SST_PRESENT;
          end else begin
            st_next = SST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= SST_IDLE;
      sh_reg    <= 16'h0000;
      left_reg  <= 5'h00;
      cnt_reg   <= '0;
      ord_reg   <= LOW_BIT_FIRST;
      dpin_reg  <= 4'h0;
      cpin_reg  <= 4'h0;
      latch_reg <= 16'h0000;
      dir_reg   <= 16'h0000;
    end else if (clk_en) begin
      st_reg    <= st_next;
      sh_reg    <= sh_next;
      left_reg  <= left_next;
      cnt_reg   <= cnt_next;
      ord_reg   <= ord_next;
      dpin_reg  <= dpin_next;
      cpin_reg  <= cpin_next;
      latch_reg <= latch_next;
      dir_reg   <= dir_next;
    end
  end

  assign pin_out = latch_reg;
  assign pin_oe  = dir_reg;
  assign busy    = (st_reg != SST_IDLE);

  // Helper logic watched only by the checks below.
  logic [CNT_W-1:0] hi_cnt_reg;
  logic [4:0]       pulses_reg;
  logic [4:0]       want_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_reg <= '0;
      pulses_reg <= 5'h00;
      want_reg   <= 5'h00;
    end else if (clk_en) begin
      hi_cnt_reg <= latch_reg[cpin_reg] ? hi_cnt_reg + CNT_W'(1) : '0;
      if (take) begin
        pulses_reg <= 5'h00;
        want_reg   <= img[20:16];
      end else if (st_reg == SST_PULSE && cnt_reg == PULSE_CNT) begin
        pulses_reg <= pulses_reg + 5'h01;
      end
    end
  end

  sequence s_clk_fall;
    busy && $fell(latch_reg[cpin_reg]);
  endsequence

  sequence s_item_done;
    st_reg == SST_LOW && cnt_reg == LOW_CNT && left_reg == 5'h01 && clk_en;
  endsequence

  property p_pulse_width;
    @(posedge pclk) disable iff (!presetn) s_clk_fall |-> hi_cnt_reg == PULSE_CNT;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("clock pulse width wrong");

  property p_data_stable;
    @(posedge pclk) disable iff (!presetn)
      (st_reg == SST_PULSE && $past(st_reg) == SST_PULSE) |-> $stable(latch_reg[dpin_reg]);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved during pulse");

  property p_oe_before_rise;
    @(posedge pclk) disable iff (!presetn)
      (busy && $rose(latch_reg[cpin_reg])) |-> (dir_reg[dpin_reg] && $past(dir_reg[dpin_reg]));
  endproperty
  a_oe_before_rise: assert property (p_oe_before_rise) else $error("clock rose before oe");

  property p_clk_low_first;
    @(posedge pclk) disable iff (!presetn)
      (st_reg == SST_CLKLOW && clk_en) |=> (dir_reg[cpin_reg] && !latch_reg[cpin_reg]);
  endproperty
  a_clk_low_first: assert property (p_clk_low_first) else $error("clock not low output");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
      (st_reg == SST_ENABLE) |->
        latch_reg[dpin_reg] == ((ord_reg == HIGH_BIT_FIRST) ? sh_reg[15] : sh_reg[0]);
  endproperty
  a_order: assert property (p_order) else $error("wrong bit presented");

  property p_default_eight;
    @(posedge pclk) disable iff (!presetn)
      (take && rd_s.data[DATA_BITS_LSB +: 5] == 5'h00) |=> left_reg == DEFAULT_BITS;
  endproperty
  a_default_eight: assert property (p_default_eight) else $error("default count not eight");

  property p_bit_total;
    @(posedge pclk) disable iff (!presetn) s_item_done |-> pulses_reg == want_reg;
  endproperty
  a_bit_total: assert property (p_bit_total) else $error("pulse count differs from bits");

  property p_next_item;
    @(posedge pclk) disable iff (!presetn)
      (s_item_done and (ctrl_reg[CTRL_EN_BIT] && rd_s.valid)) |=> st_reg == SST_PRESENT;
  endproperty
  a_next_item: assert property (p_next_item) else $error("items not back to back");

  property p_end_state;
    @(posedge pclk) disable iff (!presetn)
      (s_item_done and !(ctrl_reg[CTRL_EN_BIT] && rd_s.valid)) |=>
        (!busy && dir_reg[dpin_reg] && dir_reg[cpin_reg] && !latch_reg[cpin_reg]
         && $stable(latch_reg[dpin_reg]));
  endproperty
  a_end_state: assert property (p_end_state) else $error("pins not held at end");

endmodule : sst_top

/* tb/sst_periph_model.sv */
// Behavioural shift-register peripheral that watches the transmitter's pins.
`timescale 1ns/10ps
module sst_periph_model
  import sst_pkg::*;
(
  // Pins and the indices of the lines wired to this peripheral.
  input  wire logic [sst_pkg::NPINS-1:0] pin_out,
  input  wire logic [sst_pkg::NPINS-1:0] pin_oe,
  input  wire logic [3:0]                dpin,
  input  wire logic [3:0]                cpin,
  // Captured bit, hold check and clock high time.
  output logic                           cap_bit,
  output logic                           cap_held,
  output int                             high_ns,
  output int                             n_caps
);
  logic    sclk;
  logic    sdat;
  logic    armed;
  realtime t_rise;

  // An undriven data line floats, so a bit presented without its enable never matches.
  assign sclk = pin_oe[cpin] ? pin_out[cpin] : 1'b0;
  assign sdat = pin_oe[dpin] ? pin_out[dpin] : 1'bz;

  initial begin
    armed = 1'b0;
    n_caps = 0;
    high_ns = 0;
  end

  always @(posedge sclk) begin
    cap_bit = sdat;
    t_rise = $realtime;
    armed = 1'b1;
  end

  always @(negedge sclk) begin
    if (armed) begin
      cap_held = (sdat === cap_bit);
      high_ns = int'($realtime - t_rise);
      armed = 1'b0;
      n_caps = n_caps + 1;
    end
  end
endmodule : sst_periph_model

/* tb/sync_serial_transmit_tb.sv */
// Self-checking bench for the synchronous serial transmitter.
`timescale 1ns/10ps
module sync_serial_transmit_tb;
  import sst_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             clk_en = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [NPINS-1:0] pin_out;
  logic [NPINS-1:0] pin_oe;
  logic             busy;
  logic [3:0]       dpin = 4'h0;
  logic [3:0]       cpin = 4'h0;
  logic             order = 1'b0;
  logic             cap_bit;
  logic             cap_held;
  int               high_ns;
  int               n_caps;
  logic [31:0]      rdata;
  logic [31:0]      rnd = 32'h37391295;
  logic             rerr;
  logic             last_bit;
  logic [NPINS-1:0] exp_out = 16'h0;
  logic [NPINS-1:0] exp_oe = 16'h0;
  logic             exp_q[$];
  int               num_errors = 0;
  int               n_tests = 0;
  int               cyc = 0;
  int               seen_caps = 0;

  always #12.5 pclk = ~pclk;

  sst_top i_sst_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe), .busy(busy)
  );

  sst_periph_model i_sst_periph_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .dpin(dpin), .cpin(cpin),
    .cap_bit(cap_bit), .cap_held(cap_held), .high_ns(high_ns), .n_caps(n_caps)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Pready is sampled at the rising edge that completes the access; an idle edge follows.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic set_ctrl(input logic [3:0] dp, input logic [3:0] cp, input logic ord,
                          input logic en);
    dpin = dp;
    cpin = cp;
    order = ord;
    apb(1'b1, ADDR_CTRL, {20'h0, cp, dp, 2'b00, ord, en});
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", rdata, {20'h0, cp, dp, 2'b00, ord, en});
  endtask : set_ctrl

  task automatic push_item(input logic [15:0] v, input logic [4:0] c);
    int n;
    n = (c == 5'h00) ? 8 : ((c > 5'h10) ? 16 : int'(c));
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(order ? v[n-1-i] : v[i]);
    end
    last_bit = order ? v[0] : v[n-1];
    apb(1'b1, ADDR_DATA, {11'h0, c, v});
  endtask : push_item

  task automatic finish_xfer(input string name);
    repeat (4) @(posedge pclk);
    while (busy !== 1'b0) begin
      @(posedge pclk);
    end
    @(posedge pclk);
    exp_oe[dpin] = 1'b1;
    exp_oe[cpin] = 1'b1;
    exp_out[cpin] = 1'b0;
    exp_out[dpin] = last_bit;
    apb(1'b0, ADDR_PINS, 32'h0);
    check("pins", rdata, {exp_oe, exp_out});
    check("left", 32'(exp_q.size()), 32'h0);
    $display("test %s done", name);
  endtask : finish_xfer

  // Each completed clock pulse at the peripheral is compared with the oldest note.
  // The capture is looked at on the next clock edge, once all its values have settled.
  always @(posedge pclk) begin
    if (n_caps != seen_caps) begin
      seen_caps = n_caps;
      check("bit", {31'h0, cap_bit}, {31'h0, exp_q.pop_front()});
      check("held", {31'h0, cap_held}, 32'h1);
      check("high_ns", 32'(high_ns), 32'h36b0);
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset contents of the map and one unmapped word.
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check("reset_rd", rdata, (i == 2) ? 32'h4 : 32'h0);
      check("slverr", {31'h0, rerr}, (i == 4) ? 32'h1 : 32'h0);
    end
    $display("test reset done");
    // Fill the buffer while idle, then release it; the fourth item stalls on a full buffer.
    set_ctrl(4'h2, 4'h5, LOW_BIT_FIRST, 1'b0);
    push_item(16'ha5c3, 5'h00);
    push_item(16'hffff, 5'h01);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("full", rdata, 32'h2);
    set_ctrl(4'h2, 4'h5, LOW_BIT_FIRST, 1'b1);
    push_item(16'h8001, 5'h10);
    push_item(16'h0005, 5'h03);
    finish_xfer("buffer");
    // Random items and counts, high bit first, on other pins.
    set_ctrl(4'hf, 4'h0, HIGH_BIT_FIRST, 1'b1);
    for (int k = 0; k < 3; k++) begin
      rnd = xorshift(rnd);
      push_item(rnd[15:0], rnd[20:16]);
    end
    finish_xfer("random");
    final_report();
  end
endmodule : sync_serial_transmit_tb
